// file: design/tpg_top.v
// four-channel output test-pattern generator with its configuration registers
// Function
// (RQ1) word one high byte at 8Eh
// (RQ2) word two bytes at 8Fh, 90h
// (RQ3) select field bits 7-4 of 91h
// (RQ4) code 6 word one, 7 alternates
// (RQ5) code 8 outputs deskew word AAAA
// (RQ6) per-channel enable bits 3-0 of 91h
// (RQ7) enabled channels share one select field
// (RQ8) host always writes 1 to special bits
// (RQ9) reserved special bits read as zero
// (RQ10) reset clears all fields to zero
// (RQ11) word one low byte at 8Dh
// (RQ12) host opens page before writing registers
// (RQ13) toggle alternates, ramp increments and wraps
// (RQ14) undefined codes give default data
`timescale 1ns/10ps
`default_nettype none
`include "tpg_regs.vh"
module tpg_top #(
	parameter W = 16
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire         reg_wr_en,
	input  wire [7:0]   reg_addr,
	input  wire [7:0]   reg_wdata,
	output wire [7:0]   reg_rdata,
	output wire         reg_hit,
	input  wire         sample_en,
	input  wire [W-1:0] adc_data_a,
	input  wire [W-1:0] adc_data_b,
	input  wire [W-1:0] adc_data_c,
	input  wire [W-1:0] adc_data_d,
	output wire [W-1:0] lane_data_a,
	output wire [W-1:0] lane_data_b,
	output wire [W-1:0] lane_data_c,
	output wire [W-1:0] lane_data_d,
	output wire         mandatory_set_bit_a,
	output wire         mandatory_set_bit_b
);
	wire [15:0]      programmable_word_one;
	wire [15:0]      programmable_word_two;
	wire [3:0]       pattern_kind_field;
	wire [3:0]       pattern_channel_en;
	wire [W-1:0]     pattern_word;
	wire [4*W-1:0]   adc_bus;
	reg  [4*W-1:0]   lane_r;
	reg              kind_valid;

	// ************
	// registers and pattern source
	// ************
	// page enable (RQ12) lives outside; writes here are already page-qualified
	tpg_regfile tpg_regfile_i (
		.clk_sys               (clk_sys),
		.rst_n                 (rst_n),
		.reg_wr_en             (reg_wr_en),
		.reg_addr              (reg_addr),
		.reg_wdata             (reg_wdata),
		.reg_rdata             (reg_rdata),
		.reg_hit               (reg_hit),
		.programmable_word_one (programmable_word_one),
		.programmable_word_two (programmable_word_two),
		.pattern_kind_field    (pattern_kind_field),
		.pattern_channel_en    (pattern_channel_en),
		.mandatory_set_bit_a   (mandatory_set_bit_a),
		.mandatory_set_bit_b   (mandatory_set_bit_b)
	);

	tpg_pattern_core #(.W(W)) tpg_pattern_core_i (
		.clk_sys               (clk_sys),
		.rst_n                 (rst_n),
		.sample_en             (sample_en),
		.pattern_kind_field    (pattern_kind_field),
		.programmable_word_one (programmable_word_one),
		.programmable_word_two (programmable_word_two),
		.pattern_word          (pattern_word)
	);

	// code 0, 5 and 9..15 leave converted data in place
	always @* begin
		case (pattern_kind_field)
		`TPG_K_ZEROS, `TPG_K_ONES, `TPG_K_TOGGLE, `TPG_K_RAMP,
		`TPG_K_WORD_ONE, `TPG_K_ALTERNATE, `TPG_K_DESKEW: kind_valid = 1'b1;
		default: kind_valid = 1'b0;  // RQ14
		endcase
	end

	// ************
	// per-channel output mux
	// ************
	assign adc_bus = {adc_data_d, adc_data_c, adc_data_b, adc_data_a};

	genvar ch;
	generate
		for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
			always @(posedge clk_sys) begin
				if (!rst_n) begin
					lane_r[ch*W +: W] <= {W{1'b0}};
				end else if (sample_en) begin
					if (pattern_channel_en[ch] && kind_valid)  // RQ7
						lane_r[ch*W +: W] <= pattern_word;     // RQ7
					else
						lane_r[ch*W +: W] <= adc_bus[ch*W +: W];  // RQ6
				end
			end
		end
	endgenerate

	assign lane_data_a = lane_r[0*W +: W];
	assign lane_data_b = lane_r[1*W +: W];
	assign lane_data_c = lane_r[2*W +: W];
	assign lane_data_d = lane_r[3*W +: W];
endmodule
`default_nettype wire

// file: design/tpg_regs.vh
// register map and constants of the output test-pattern generator
`ifndef TPG_REGS_VH
`define TPG_REGS_VH
`define TPG_ADDR_W        8
`define TPG_OFF_P1_LO     8'h8D
`define TPG_OFF_P1_HI     8'h8E
`define TPG_OFF_P2_LO     8'h8F
`define TPG_OFF_P2_HI     8'h90
`define TPG_OFF_SEL_EN    8'h91
`define TPG_OFF_SPEC_A    8'hAB
`define TPG_OFF_SPEC_B    8'hAC
`define TPG_RST_BYTE      8'h00
`define TPG_SEL_MSB       7
`define TPG_SEL_LSB       4
`define TPG_EN_MSB        3
`define TPG_EN_LSB        0
`define TPG_SPEC_BIT      0
`define TPG_K_DEFAULT     4'h0
`define TPG_K_ZEROS       4'h1
`define TPG_K_ONES        4'h2
`define TPG_K_TOGGLE      4'h3
`define TPG_K_RAMP        4'h4
`define TPG_K_WORD_ONE    4'h6
`define TPG_K_ALTERNATE   4'h7
`define TPG_K_DESKEW      4'h8
`define TPG_DESKEW_WORD   16'hAAAA
`endif

// file: design/tpg_regfile.v
// byte-wide configuration registers of the digital configuration page
`timescale 1ns/10ps
`default_nettype none
`include "tpg_regs.vh"
module tpg_regfile (
	input  wire        clk_sys,
	input  wire        rst_n,
	input  wire        reg_wr_en,
	input  wire [7:0]  reg_addr,
	input  wire [7:0]  reg_wdata,
	output reg  [7:0]  reg_rdata,
	output wire        reg_hit,
	output reg  [15:0] programmable_word_one,
	output reg  [15:0] programmable_word_two,
	output reg  [3:0]  pattern_kind_field,
	output reg  [3:0]  pattern_channel_en,
	output reg         mandatory_set_bit_a,
	output reg         mandatory_set_bit_b
);
	// ************
	// write side
	// ************
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			programmable_word_one <= {2{`TPG_RST_BYTE}};  // RQ10
			programmable_word_two <= {2{`TPG_RST_BYTE}};
			pattern_kind_field    <= 4'h0;
			pattern_channel_en    <= 4'h0;
			mandatory_set_bit_a   <= 1'b0;
			mandatory_set_bit_b   <= 1'b0;
		end else if (reg_wr_en) begin
			case (reg_addr)
			`TPG_OFF_P1_LO: programmable_word_one[7:0] <= reg_wdata;   // RQ11
			`TPG_OFF_P1_HI: programmable_word_one[15:8] <= reg_wdata;  // RQ1
			`TPG_OFF_P2_LO: programmable_word_two[7:0] <= reg_wdata;   // RQ2
			`TPG_OFF_P2_HI: programmable_word_two[15:8] <= reg_wdata;  // RQ2
			`TPG_OFF_SEL_EN: begin
				pattern_kind_field <= reg_wdata[`TPG_SEL_MSB:`TPG_SEL_LSB];  // RQ3
				pattern_channel_en <= reg_wdata[`TPG_EN_MSB:`TPG_EN_LSB];    // RQ6
			end
			// reserved bits are not stored, so they always read 0
			`TPG_OFF_SPEC_A: mandatory_set_bit_a <= reg_wdata[`TPG_SPEC_BIT];  // RQ9
			`TPG_OFF_SPEC_B: mandatory_set_bit_b <= reg_wdata[`TPG_SPEC_BIT];  // RQ9
			default: ;
			endcase
		end
	end

	// ************
	// read side
	// ************
	assign reg_hit = (reg_addr == `TPG_OFF_P1_LO) || (reg_addr == `TPG_OFF_P1_HI) ||
		(reg_addr == `TPG_OFF_P2_LO) || (reg_addr == `TPG_OFF_P2_HI) ||
		(reg_addr == `TPG_OFF_SEL_EN) || (reg_addr == `TPG_OFF_SPEC_A) ||
		(reg_addr == `TPG_OFF_SPEC_B);

	always @* begin
		case (reg_addr)
		`TPG_OFF_P1_LO:  reg_rdata = programmable_word_one[7:0];
		`TPG_OFF_P1_HI:  reg_rdata = programmable_word_one[15:8];
		`TPG_OFF_P2_LO:  reg_rdata = programmable_word_two[7:0];
		`TPG_OFF_P2_HI:  reg_rdata = programmable_word_two[15:8];
		`TPG_OFF_SEL_EN: reg_rdata = {pattern_kind_field, pattern_channel_en};
		`TPG_OFF_SPEC_A: reg_rdata = {7'h00, mandatory_set_bit_a};  // RQ9
		`TPG_OFF_SPEC_B: reg_rdata = {7'h00, mandatory_set_bit_b};  // RQ9
		default:         reg_rdata = 8'h00;
		endcase
	end
endmodule
`default_nettype wire

// file: design/tpg_pattern_core.v
// shared pattern word source: toggle, ramp, alternation and fixed words
`timescale 1ns/10ps
`default_nettype none
`include "tpg_regs.vh"
module tpg_pattern_core #(
	parameter W = 16
) (
	input  wire         clk_sys,
	input  wire         rst_n,
	input  wire         sample_en,
	input  wire [3:0]   pattern_kind_field,
	input  wire [15:0]  programmable_word_one,
	input  wire [15:0]  programmable_word_two,
	output reg  [W-1:0] pattern_word
);
	reg         phase_r;
	reg [W-1:0] ramp_r;

	// ************
	// sequence state
	// ************
	// one phase bit drives both toggle and alternation, one sample per step
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			phase_r <= 1'b0;
			ramp_r  <= {W{1'b0}};
		end else if (sample_en) begin
			phase_r <= ~phase_r;           // RQ13
			ramp_r  <= ramp_r + 1'b1;      // RQ13
		end
	end

	// ************
	// word select
	// ************
	always @* begin
		case (pattern_kind_field)
		`TPG_K_ZEROS:     pattern_word = {W{1'b0}};                   // RQ3
		`TPG_K_ONES:      pattern_word = {W{1'b1}};                   // RQ3
		`TPG_K_TOGGLE:    pattern_word = {W{phase_r}};                // RQ13
		`TPG_K_RAMP:      pattern_word = ramp_r;                      // RQ13
		`TPG_K_WORD_ONE:  pattern_word = programmable_word_one[W-1:0];  // RQ4
		`TPG_K_ALTERNATE: pattern_word = phase_r ? programmable_word_two[W-1:0]
			: programmable_word_one[W-1:0];                          // RQ4
		`TPG_K_DESKEW:    pattern_word = `TPG_DESKEW_WORD;            // RQ5
		default:          pattern_word = {W{1'b0}};
		endcase
	end
endmodule
`default_nettype wire

// file: testbench/tpg_top_chk.sv
// port assertions of the pattern generator
`timescale 1ns/10ps
`default_nettype none
module tpg_top_chk #(parameter W = 16) (
	input wire logic         clk_sys,
	input wire logic         rst_n,
	input wire logic         reg_wr_en,
	input wire logic [7:0]   reg_addr,
	input wire logic [7:0]   reg_wdata,
	input wire logic [7:0]   reg_rdata,
	input wire logic         sample_en,
	input wire logic [W-1:0] adc_data_a,
	input wire logic [W-1:0] lane_data_a,
	input wire logic [W-1:0] lane_data_c,
	input wire logic         mandatory_set_bit_a
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// only judged while the select register is on the read port
	wire smp = sample_en && !reg_wr_en && reg_addr == 8'h91;
	a_word_one_hi: assert property (reg_wr_en && reg_addr == 8'h8E |=>
		reg_addr != 8'h8E || reg_rdata == $past(reg_wdata)) else $error("word one lost");
	a_word_two_lo: assert property (reg_wr_en && reg_addr == 8'h8F |=>
		reg_addr != 8'h8F || reg_rdata == $past(reg_wdata)) else $error("word two lost");
	a_select_kept: assert property (reg_wr_en && reg_addr == 8'h91 |=>
		reg_addr != 8'h91 || reg_rdata == $past(reg_wdata)) else $error("select lost");
	a_spec_reserved: assert property (reg_addr == 8'hAB || reg_addr == 8'hAC |->
		reg_rdata[7:1] == 7'h00) else $error("reserved bits set");
	a_spec_a_kept: assert property (reg_wr_en && reg_addr == 8'hAB |=>
		mandatory_set_bit_a == $past(reg_wdata[0])) else $error("special bit lost");
	a_reset_clear: assert property (disable iff (1'b0) !rst_n |=>
		lane_data_a == '0 && !mandatory_set_bit_a) else $error("reset left state");
	a_lane_hold: assert property (!sample_en |=>
		$stable(lane_data_a) && $stable(lane_data_c)) else $error("lane moved");
	a_pass_when_off: assert property (smp && !reg_rdata[0] |=>
		lane_data_a == $past(adc_data_a)) else $error("lane not passing data");
	a_deskew_word: assert property (smp && reg_rdata == 8'h85 |=>
		lane_data_a == 16'hAAAA && lane_data_c == 16'hAAAA) else $error("deskew wrong");
endmodule
bind tpg_top tpg_top_chk #(.W(W)) tpg_top_chk_i (.clk_sys(clk_sys), .rst_n(rst_n),
	.reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .sample_en(sample_en), .adc_data_a(adc_data_a),
	.lane_data_a(lane_data_a), .lane_data_c(lane_data_c),
	.mandatory_set_bit_a(mandatory_set_bit_a));
`default_nettype wire

// file: testbench/tpg_sample_src.sv
// converter side model: sample pacing and converted words
`timescale 1ns/10ps
`default_nettype none
module tpg_sample_src (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	output var  logic        sample_en,
	output wire logic [47:0] adc_abc,
	output wire logic [15:0] adc_data_d
);
	logic [11:0] cnt_r;
	assign adc_abc = {cnt_r, 4'hA, cnt_r, 4'hB, cnt_r, 4'hC};
	assign adc_data_d = {cnt_r, 4'hD};
	// data moves only off sample edges so a taken word can be compared
	always @(posedge clk_sys) begin
		sample_en <= rst_n & ~sample_en;
		cnt_r <= !rst_n ? 12'h000 : cnt_r + {11'h000, ~sample_en};
	end
endmodule
`default_nettype wire

// file: testbench/tpg_top_bench.sv
// self-checking bench of the four-channel pattern generator
`timescale 1ns/10ps
`default_nettype none
module tpg_top_bench;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        reg_wr_en = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic [7:0]  reg_rdata;
	logic        reg_hit, sample_en, bit_a, bit_b;
	logic [47:0] adc;
	logic [15:0] adc_d, lane_a, lane_b, lane_c, lane_d, s0, s1;
	int          miscompares = 0;
	int          checks = 0;
	tpg_sample_src tpg_sample_src_i (.clk_sys(clk_sys), .rst_n(rst_n),
		.sample_en(sample_en), .adc_abc(adc), .adc_data_d(adc_d));
	tpg_top tpg_top_i (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_hit(reg_hit), .sample_en(sample_en), .adc_data_a(adc[47:32]),
		.adc_data_b(adc[31:16]), .adc_data_c(adc[15:0]), .adc_data_d(adc_d),
		.lane_data_a(lane_a), .lane_data_b(lane_b), .lane_data_c(lane_c),
		.lane_data_d(lane_d), .mandatory_set_bit_a(bit_a), .mandatory_set_bit_b(bit_b));
	initial forever #2.5 clk_sys = ~clk_sys;
	task automatic chk(input logic [15:0] seen, exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge clk_sys);
		reg_wr_en <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, e);
		@(posedge clk_sys);
		reg_addr <= a;
		#1 chk(reg_rdata, e);
	endtask
	task automatic grab(output logic [15:0] v);
		@(posedge clk_sys iff sample_en);
		#1 v = lane_a;
	endtask
	// ****
	// scenarios; run enables channels a and c, b and d left on data
	// ****
	task automatic run(input logic [3:0] k, input logic dflt);
		wr(8'h91, {k, 4'h5});
		repeat (3) grab(s0);
		chk(lane_c, dflt ? adc[15:0] : s0);
		chk(lane_b, adc[31:16]);
		chk(lane_d, adc_d);
		grab(s1);
	endtask
	task automatic t_regs;
		logic [7:0] a[6] = '{8'h8D, 8'h8E, 8'h8F, 8'h90, 8'hAB, 8'hAC};
		logic [7:0] d[6] = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h01, 8'h01};
		foreach (a[i]) rd(a[i], 8'h00);
		foreach (a[i]) wr(a[i], d[i]);
		rd(8'h8D, 8'h34);
		chk(reg_hit, 1'b1);
		rd(8'h8E, 8'h12);
		rd(8'h90, 8'h56);
		rd(8'hAB, 8'h01);
		rd(8'hAC, 8'h01);
		chk(bit_a & bit_b, 1'b1);
		rd(8'h92, 8'h00);
		chk(reg_hit, 1'b0);
	endtask
	task automatic t_fixed;
		logic [3:0] k[8] = '{4'h0, 4'h1, 4'h2, 4'h5, 4'h6, 4'h8, 4'h9, 4'hF};
		logic [15:0] e;
		foreach (k[i]) begin
			run(k[i], k[i] == 4'h0 || k[i] == 4'h5 || k[i] >= 4'h9);
			e = k[i] == 4'h1 ? 16'h0000 : k[i] == 4'h2 ? 16'hFFFF : k[i] == 4'h6 ? 16'h1234
				: k[i] == 4'h8 ? 16'hAAAA : adc[47:32];
			chk(s1, e);
		end
	endtask
	task automatic t_moving;
		run(4'h3, 1'b0);
		chk(s0 ^ s1, 16'hFFFF);
		chk(s0 ^ {16{s0[0]}}, 16'h0000);
		run(4'h4, 1'b0);
		chk(s1, s0 + 16'h0001);
		run(4'h7, 1'b0);
		chk(s0 ^ s1, 16'h1234 ^ 16'h5678);
		// zeros on b and d only: checks the enable bit order
		wr(8'h91, 8'h1A);
		grab(s0);
		chk(lane_b | lane_d, 16'h0000);
		chk(s0, adc[47:32]);
		chk(lane_c, adc[15:0]);
	endtask
	task automatic t_rerst;
		@(posedge clk_sys);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(8'h91, 8'h00);
		chk(lane_a, 16'h0000);
		grab(s0);
		chk(s0, adc[47:32]);
		// let the checker see the cycle after the last sample
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic final_report;
		if (miscompares == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_regs;
		t_fixed;
		t_moving;
		t_rerst;
		final_report;
	end
	// bound is about twenty-five times the expected run
	initial begin
		#20000;
		miscompares++;
		final_report;
	end
endmodule
`default_nettype wire
